/* File: hw/onoff_cfg.svh */
// Register map, field positions, reset values for the on/off block
// Included by the package user files; definitions only
`ifndef ONOFF_CFG_SVH
`define ONOFF_CFG_SVH

// Command codes on the register port
`define OPCTL_ADDR      8'h01
`define POLICY_ADDR     8'h02

// Reset values
`define OPCTL_RST       8'h00
`define POLICY_RST      8'h17

// Control byte fields
`define OPC_ON_BIT      7
`define OPC_SOFT_BIT    6
`define OPC_SRC_HI      5
`define OPC_SRC_LO      4
`define OPC_MFR_HI      3
`define OPC_MFR_LO      2

// Policy byte fields
`define POL_GATED_BIT   4
`define POL_BUS_BIT     3
`define POL_PIN_BIT     2
`define POL_POLAR_BIT   1
`define POL_PINOFF_BIT  0

`endif

/* File: hw/onoff_pkg.sv */
// Types shared by the on/off control files
// No surroundings assumed
package onoff_pkg;

    // Setpoint source that applies while on
    typedef enum logic [1:0] {
        VSEL_NOMINAL,
        VSEL_MARGIN_LOW,
        VSEL_MARGIN_HIGH
    } vsel_t;

    // Output power state
    typedef enum logic {
        PWR_OFF,
        PWR_ON
    } pwr_state_t;

endpackage

/* File: hw/pin_sync.sv */
// Three-stage synchroniser for the enable pin
// Assumes an asynchronous pin and one system clock
`timescale 1ns/1ps

module pin_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      level
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level <= 1'b0;
        end else if (s2_r == s3_r) begin
            level <= s3_r;
        end
    end

endmodule

/* File: hw/output_on_off_margin_control.sv */
// Output on/off, shutdown style and setpoint selection from two command bytes
// Assumes a command port from the bus engine and an async enable pin
//
// Notes on behaviour
// (R1) Control byte plus pin set operating state
// (R2) Control bit 7 commands output on or off
// (R3) Bit 6 picks immediate or sequenced bus turn-off
// (R4) Bits 5:4 pick nominal, low or high setpoint
// (R5) Bits 3:2 ignore or act on margin faults
// (R6) Control bits 1:0 always read zero
// (R7) Eight listed patterns raise invalid-data fault
// (R8) Any other control byte is stored, no fault
// (R9) Both bytes copied out on store-all command
// (R10) Policy byte, bits 7:5 reserved, reset zero
// (R11) Policy bit 4: always on or gated
// (R12) Policy bit 3: use control bit 7 or not
// (R13) Policy bit 2: use enable pin or not
// (R14) Policy bit 1 polarity, active high only
// (R15) Policy bit 0: pin turn-off immediate or sequenced
// (R16) Bits 3 and 2 set need both conditions
// (R17) Invalid data discarded, comm fault bits set
// (R18) Policy 1101 bus only, 1111 both
// (R19) Writing polarity zero never inverts the pin
// (R20) Unlisted patterns stored, fields decoded independently; code sets margin flags only with a margin setpoint
`timescale 1ns/1ps
`include "onoff_cfg.svh"

module output_on_off_margin_control (
    input  wire logic           clk,
    input  wire logic           rst_b,
    input  wire logic           wr_stb,
    input  wire logic           rd_stb,
    input  wire logic [7:0]     cmd_code,
    input  wire logic [7:0]     wr_data,
    input  wire logic           clear_faults,
    input  wire logic           store_stb,
    input  wire logic           enable_pin,
    output logic [7:0]          rd_data,
    output logic                ack,
    output logic                cml_fault,
    output logic                inv_data,
    output logic [7:0]          nvm_opctl,
    output logic [7:0]          nvm_policy,
    output logic                nvm_wr,
    output logic                out_on,
    output logic                off_now,
    output logic                off_seq,
    output onoff_pkg::vsel_t    vsel,
    output logic                margin_ignore,
    output logic                margin_act
);

    import onoff_pkg::*;

    logic [7:0] opctl_r;
    logic [7:0] policy_r;
    logic       en_s;
    logic       run_c;
    logic       pin_block_c;
    logic       bad_wr_c;
    pwr_state_t state_r;
    pwr_state_t state_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Listed invalid control patterns on bits 7:2
    function automatic logic is_invalid(input logic [7:0] b);
        logic [5:0] f;
        f = b[7:2];
        case (f)
            6'h24, 6'h34, 6'h27, 6'h37, 6'h28, 6'h38, 6'h2b, 6'h3b: is_invalid = 1'b1;
            default: is_invalid = 1'b0;
        endcase
    endfunction

    // Setpoint source from bits 5:4; code 11 falls back to nominal
    function automatic vsel_t src_of(input logic [7:0] b);
        case (b[`OPC_SRC_HI:`OPC_SRC_LO])
            2'b01:   src_of = VSEL_MARGIN_LOW;
            2'b10:   src_of = VSEL_MARGIN_HIGH;
            default: src_of = VSEL_NOMINAL;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Enable pin

    // Pin synchronised, always treated active high
    pin_sync u_pin_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   (enable_pin),
        .level (en_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    assign bad_wr_c = wr_stb && (cmd_code == `OPCTL_ADDR) && is_invalid(wr_data);

    // (R6) (R7) (R8) (R20) store control byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            opctl_r <= `OPCTL_RST;
        end else if (wr_stb && cmd_code == `OPCTL_ADDR && !is_invalid(wr_data)) begin
            opctl_r <= {wr_data[7:2], 2'b00};
        end
    end

    // (R10) (R14) (R19) store policy, polarity pinned high
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            policy_r <= `POLICY_RST;
        end else if (wr_stb && cmd_code == `POLICY_ADDR) begin
            policy_r <= {wr_data[7:2], 1'b1, wr_data[0]};
        end
    end

    // (R17) sticky fault flags, set beats clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cml_fault <= 1'b0;
            inv_data  <= 1'b0;
        end else if (bad_wr_c) begin
            cml_fault <= 1'b1;
            inv_data  <= 1'b1;
        end else if (clear_faults) begin
            cml_fault <= 1'b0;
            inv_data  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads

    // Read data and one-cycle acknowledge; unmapped reads return zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
            ack     <= 1'b0;
        end else begin
            ack <= wr_stb || rd_stb;
            if (rd_stb) begin
                case (cmd_code)
                    `OPCTL_ADDR:  rd_data <= opctl_r;
                    `POLICY_ADDR: rd_data <= policy_r;
                    default:      rd_data <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Nonvolatile copy

    // (R9) snapshot both bytes on store-all
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nvm_opctl  <= 8'h00;
            nvm_policy <= 8'h00;
            nvm_wr     <= 1'b0;
        end else begin
            nvm_wr <= store_stb;
            if (store_stb) begin
                nvm_opctl  <= opctl_r;
                nvm_policy <= policy_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Turn-on decision

    // (R11) (R12) (R13) (R16) (R18) run condition
    always_comb begin
        pin_block_c = policy_r[`POL_PIN_BIT] && !en_s;
        if (!policy_r[`POL_GATED_BIT]) begin
            run_c = 1'b1;
        end else begin
            run_c = !pin_block_c && (!policy_r[`POL_BUS_BIT] || opctl_r[`OPC_ON_BIT]);
        end
    end

    // (R1) (R2) power state follows the run condition
    always_comb begin
        state_nxt = run_c ? PWR_ON : PWR_OFF;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= PWR_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Registered copy of the on state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_on <= 1'b0;
        end else begin
            out_on <= run_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Turn-off style

    // (R3) (R15) pulse immediate or sequenced shutdown
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            off_now <= 1'b0;
            off_seq <= 1'b0;
        end else begin
            off_now <= 1'b0;
            off_seq <= 1'b0;
            case (state_r)
                PWR_ON: begin
                    if (!run_c) begin
                        if (pin_block_c) begin
                            off_now <= policy_r[`POL_PINOFF_BIT];
                            off_seq <= !policy_r[`POL_PINOFF_BIT];
                        end else begin
                            off_now <= !opctl_r[`OPC_SOFT_BIT];
                            off_seq <= opctl_r[`OPC_SOFT_BIT];
                        end
                    end
                end
                PWR_OFF: begin
                    off_now <= 1'b0;
                end
                default: begin
                    off_now <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Setpoint and margin fault handling

    // (R4) (R5) (R20) setpoint decode while on; margin flags only while a margin setpoint is selected
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vsel          <= VSEL_NOMINAL;
            margin_ignore <= 1'b0;
            margin_act    <= 1'b0;
        end else begin
            vsel          <= run_c ? src_of(opctl_r) : VSEL_NOMINAL;
            margin_ignore <= run_c && (src_of(opctl_r) != VSEL_NOMINAL)
                             && (opctl_r[`OPC_MFR_HI:`OPC_MFR_LO] == 2'b01);
            margin_act    <= run_c && (src_of(opctl_r) != VSEL_NOMINAL)
                             && (opctl_r[`OPC_MFR_HI:`OPC_MFR_LO] == 2'b10);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_bad_op_kept: assert property (  // (R7)
        @(posedge clk) disable iff (!rst_b) bad_wr_c |=> $stable(opctl_r))
        else $error("invalid control byte was stored");

    a_bad_op_flags: assert property (  // (R17)
        @(posedge clk) disable iff (!rst_b) bad_wr_c |=> (cml_fault && inv_data))
        else $error("invalid control byte did not flag faults");

    a_good_op_stored: assert property (  // (R8)
        @(posedge clk) disable iff (!rst_b)
        (wr_stb && cmd_code == `OPCTL_ADDR && !is_invalid(wr_data))
        |=> (opctl_r == {$past(wr_data[7:2]), 2'b00}))
        else $error("valid control byte not stored");

    a_low_bits_zero: assert property (  // (R6)
        @(posedge clk) disable iff (!rst_b) opctl_r[1:0] == 2'b00)
        else $error("control bits 1:0 not zero");

    a_polarity_high: assert property (  // (R19)
        @(posedge clk) disable iff (!rst_b) policy_r[`POL_POLAR_BIT])
        else $error("enable polarity not active high");

    a_always_on: assert property (  // (R11)
        @(posedge clk) disable iff (!rst_b) !policy_r[`POL_GATED_BIT] |=> out_on)
        else $error("ungated policy did not keep output on");

    a_bus_off: assert property (  // (R12)
        @(posedge clk) disable iff (!rst_b)
        (policy_r[`POL_GATED_BIT] && policy_r[`POL_BUS_BIT] && !opctl_r[`OPC_ON_BIT])
        |=> !out_on)
        else $error("bus off bit ignored");

    a_both_needed: assert property (  // (R16)
        @(posedge clk) disable iff (!rst_b)
        (policy_r[4:1] == 4'b1111 && !(en_s && opctl_r[`OPC_ON_BIT])) |=> !out_on)
        else $error("output on without both conditions");

    a_bus_imm_off: assert property (  // (R3)
        @(posedge clk) disable iff (!rst_b)
        (state_r == PWR_ON && !run_c && !pin_block_c && !opctl_r[`OPC_SOFT_BIT])
        |=> (off_now && !off_seq))
        else $error("bus turn-off not immediate");

    a_pin_seq_off: assert property (  // (R15)
        @(posedge clk) disable iff (!rst_b)
        (state_r == PWR_ON && !run_c && pin_block_c && !policy_r[`POL_PINOFF_BIT])
        |=> (off_seq && !off_now))
        else $error("pin turn-off not sequenced");

    a_store_copy: assert property (  // (R9)
        @(posedge clk) disable iff (!rst_b)
        store_stb |=> (nvm_wr && nvm_opctl == $past(opctl_r) && nvm_policy == $past(policy_r)))
        else $error("store-all copy mismatch");

    a_margin_high: assert property (  // (R4)
        @(posedge clk) disable iff (!rst_b)
        (run_c && opctl_r[5:4] == 2'b10) |=> (vsel == VSEL_MARGIN_HIGH))
        else $error("margin high not selected");

    a_margin_ignore: assert property (  // (R5)
        @(posedge clk) disable iff (!rst_b)
        (run_c && opctl_r[5:4] == 2'b01 && opctl_r[3:2] == 2'b01) |=> (margin_ignore && !margin_act))
        else $error("margin faults not ignored");

    a_pin_imm_off: assert property (  // (R15)
        @(posedge clk) disable iff (!rst_b)
        (state_r == PWR_ON && !run_c && pin_block_c && policy_r[`POL_PINOFF_BIT])
        |=> (off_now && !off_seq))
        else $error("pin turn-off not immediate");

    a_bus_seq_off: assert property (  // (R3)
        @(posedge clk) disable iff (!rst_b)
        (state_r == PWR_ON && !run_c && !pin_block_c && opctl_r[`OPC_SOFT_BIT])
        |=> (off_seq && !off_now))
        else $error("bus turn-off not sequenced");

    a_bus_only_on: assert property (  // (R18)
        @(posedge clk) disable iff (!rst_b)
        (policy_r[4:1] == 4'b1101 && opctl_r[`OPC_ON_BIT]) |=> out_on)
        else $error("bus-only policy did not turn on");

    a_off_nominal: assert property (  // (R4)
        @(posedge clk) disable iff (!rst_b)
        !run_c |=> (vsel == VSEL_NOMINAL && !margin_ignore && !margin_act))
        else $error("setpoint not nominal while off");

    a_clear_flags: assert property (  // (R17)
        @(posedge clk) disable iff (!rst_b)
        (clear_faults && !bad_wr_c) |=> (!cml_fault && !inv_data))
        else $error("fault flags not cleared");

endmodule

/* File: testbench/host_model.sv */
// Bus host and enable pin driver for the on/off block
// Assumes one clock; every drive after init is non-blocking at the rising edge
`timescale 1ns/1ps

module host_model (
    input  wire logic       clk,
    input  wire logic       ack,
    output logic            wr_stb,
    output logic            rd_stb,
    output logic [7:0]      cmd_code,
    output logic [7:0]      wr_data,
    output logic            clear_faults,
    output logic            store_stb,
    output logic            enable_pin
);
    // Idle bus, called once at time zero
    task automatic init();
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        cmd_code = 8'h00;
        wr_data = 8'h00;
        clear_faults = 1'b0;
        store_stb = 1'b0;
        enable_pin = 1'b0;
    endtask

    // One byte request, one-cycle strobe, bounded wait for ack
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic got);
        int i;
        @(posedge clk);
        wr_stb <= w;
        rd_stb <= !w;
        cmd_code <= a;
        wr_data <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        wr_data <= ~d; // Stale data is not held
        cmd_code <= ~a;
        got = 1'b0;
        for (i = 0; i < 4 && got !== 1'b1; i++) begin
            #1;
            got = ack;
            if (got !== 1'b1) @(posedge clk);
        end
    endtask

    // One-cycle pulse: 0 clear faults, 1 store all
    task automatic pulse(input logic s);
        @(posedge clk);
        store_stb <= s;
        clear_faults <= !s;
        @(posedge clk);
        store_stb <= 1'b0;
        clear_faults <= 1'b0;
        #1;
    endtask

    task automatic set_pin(input logic v);
        @(posedge clk);
        enable_pin <= v;
    endtask
endmodule

/* File: testbench/test_output_on_off_margin_control.sv */
// Self-checking bench for the on/off and margin block
// Assumes host_model drives the command port and the enable pin
`timescale 1ns/1ps

module test_output_on_off_margin_control;
    import onoff_pkg::*;
    logic        clk, rst_b, wr_stb, rd_stb, clear_faults, store_stb, enable_pin;
    logic        ack, cml_fault, inv_data, nvm_wr, out_on, off_now, off_seq;
    logic        margin_ignore, margin_act, got;
    logic [7:0]  cmd_code, wr_data, rd_data, nvm_opctl, nvm_policy, v;
    vsel_t       vsel;
    int          failures, n_tests, n_now, n_seq, cyc, a, i;
    logic [7:0]  mtab [6] = '{8'h94, 8'h98, 8'ha4, 8'ha8, 8'hbc, 8'h83};
    logic [7:0]  etab [6] = '{8'h06, 8'h05, 8'h0a, 8'h09, 8'h00, 8'h00};
    logic [5:0]  bad [8] = '{6'h24, 6'h34, 6'h27, 6'h37, 6'h28, 6'h38, 6'h2b, 6'h3b};

    output_on_off_margin_control uut (.clk(clk), .rst_b(rst_b), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .cmd_code(cmd_code), .wr_data(wr_data),
        .clear_faults(clear_faults), .store_stb(store_stb), .enable_pin(enable_pin),
        .rd_data(rd_data), .ack(ack), .cml_fault(cml_fault), .inv_data(inv_data),
        .nvm_opctl(nvm_opctl), .nvm_policy(nvm_policy), .nvm_wr(nvm_wr),
        .out_on(out_on), .off_now(off_now), .off_seq(off_seq), .vsel(vsel),
        .margin_ignore(margin_ignore), .margin_act(margin_act));

    host_model host (.clk(clk), .ack(ack), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .cmd_code(cmd_code), .wr_data(wr_data), .clear_faults(clear_faults),
        .store_stb(store_stb), .enable_pin(enable_pin));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, shutdown pulse counters, hang guard
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        n_now += (off_now === 1'b1);
        n_seq += (off_seq === 1'b1);
        cyc++;
        if (cyc == 6000) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        host.xfer(1'b1, ad, d, got);
        chk(8'(got), 8'h01);
    endtask

    task automatic rd(input logic [7:0] ad);
        host.xfer(1'b0, ad, 8'h00, got);
        v = rd_data;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic results();
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        rd(8'h01);
        chk(v, 8'h00);
        rd(8'h02);
        chk(v, 8'h17);
        chk(8'(out_on), 8'h00);
        rd(8'h30);
        chk(v, 8'h00);
    endtask

    task automatic t_bus_only();
        wr(8'h02, 8'h19);
        rd(8'h02);
        chk(v, 8'h1b);
        wr(8'h01, 8'h80);
        idle(2);
        chk(8'(out_on), 8'h01);
        a = n_now;
        wr(8'h01, 8'h00);
        idle(3);
        chk(8'(out_on), 8'h00);
        chk(8'(n_now - a), 8'h01);
        wr(8'h01, 8'hc0);
        idle(2);
        a = n_seq;
        wr(8'h01, 8'h40);
        idle(3);
        chk(8'(n_seq - a), 8'h01);
    endtask

    task automatic t_margin();
        for (i = 0; i < 6; i++) begin
            wr(8'h01, mtab[i]);
            idle(2);
            chk({4'h0, vsel, margin_ignore, margin_act}, etab[i]);
            rd(8'h01);
            chk(v, mtab[i] & 8'hfc);
        end
    endtask

    task automatic t_invalid();
        for (i = 0; i < 8; i++) begin
            wr(8'h01, {bad[i], 2'b11});
            chk({6'h00, cml_fault, inv_data}, 8'h03);
            rd(8'h01);
            chk(v, 8'h80);
            host.pulse(1'b0);
            chk({6'h00, cml_fault, inv_data}, 8'h00);
        end
        wr(8'h01, 8'hb3);
        rd(8'h01);
        chk(v, 8'hb0);
        chk({6'h00, cml_fault, inv_data}, 8'h00);
        wr(8'h30, 8'hff);
        rd(8'h01);
        chk(v, 8'hb0);
    endtask

    task automatic t_pin();
        wr(8'h02, 8'h1d);
        wr(8'h01, 8'h80);
        idle(6);
        chk(8'(out_on), 8'h00);
        host.set_pin(1'b1);
        idle(6);
        chk(8'(out_on), 8'h01);
        a = n_now;
        host.set_pin(1'b0);
        idle(6);
        chk(8'(n_now - a), 8'h01);
        wr(8'h02, 8'h1e);
        host.set_pin(1'b1);
        idle(6);
        a = n_seq;
        host.set_pin(1'b0);
        idle(6);
        chk(8'(n_seq - a), 8'h01);
        wr(8'h02, 8'h07);
        wr(8'h01, 8'h00);
        idle(2);
        chk(8'(out_on), 8'h01);
    endtask

    task automatic t_store();
        wr(8'h02, 8'h1b);
        wr(8'h01, 8'h98);
        host.pulse(1'b1);
        chk(8'(nvm_wr), 8'h01);
        chk(nvm_opctl, 8'h98);
        chk(nvm_policy, 8'h1b);
    endtask

    // Reset in mid-run with output on and faults raised
    task automatic t_mid_reset();
        wr(8'h01, 8'h90);
        chk({6'h00, cml_fault, inv_data}, 8'h03);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk({6'h00, cml_fault, inv_data}, 8'h00);
        t_reset();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        failures = 0;
        n_tests = 0;
        n_now = 0;
        n_seq = 0;
        cyc = 0;
        host.init();
        rst_b = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_bus_only();
        t_margin();
        t_invalid();
        t_pin();
        t_store();
        t_mid_reset();
        results();
    end
endmodule
